/* File: src/pbcs_map.svh */
// register map, field positions, reset values and timing counts of the
// base clock selector; assumes 32-bit apb data with byte addresses
`ifndef PBCS_MAP_SVH
`define PBCS_MAP_SVH

// register indices as printed; the byte address is four times the index
`define PBCS_IDX_CTRL      8'h1c
`define PBCS_IDX_BW        8'h1d
`define PBCS_IDX_PROG      8'h1e
`define PBCS_ADDR_CTRL     (`PBCS_IDX_CTRL * 8'h04)
`define PBCS_ADDR_BW       (`PBCS_IDX_BW * 8'h04)
`define PBCS_ADDR_PROG     (`PBCS_IDX_PROG * 8'h04)

// control register fields
`define PBCS_CTRL_IE       7
`define PBCS_CTRL_FLAG     6
`define PBCS_CTRL_ON       5
`define PBCS_CTRL_SEL      4
`define PBCS_CTRL_ONES     4'hf

// bandwidth register fields
`define PBCS_BW_AUTO       7
`define PBCS_BW_LOCK       6
`define PBCS_BW_ACQ        5

// programming register: multiplier high nibble, range low nibble
`define PBCS_MUL_RST       4'h6
`define PBCS_VRS_RST       4'h6
`define PBCS_CODE_ZERO     4'h0
`define PBCS_MUL_ONE       4'h1

// source cycles waited on each side of a switch
`define PBCS_SWITCH_CYC    3

`endif

/* File: src/pbcs_pkg.sv */
// types shared by the base clock selector and its bench
// assumes the map header supplies the numeric constants
package pbcs_pkg;

  // apb request as driven by the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pbcs_apb_req_s;

  // apb answer of the slave
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pbcs_apb_rsp_s;

  // settings handed to the analog pll
  typedef struct packed {
    logic       enable;
    logic       track;
    logic [3:0] mul;
    logic [3:0] vrs;
  } pbcs_pll_cfg_s;

  // source switch state
  typedef enum logic [0:0] {
    PBCS_RUN  = 1'b0,
    PBCS_HOLD = 1'b1
  } pbcs_sw_e;

endpackage

/* File: src/pbcs_top.sv */
// base clock selector: pll control registers on apb, source interlocks,
// glitch-free crystal/vco hand-over and divide-by-two base clock
// assumes crystal and vco clock levels arrive synchronous to I_SYS_CLK
// and that each runs well below half the system clock rate
`include "pbcs_map.svh"
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - multiplier code zero acts as one
// - range zero disables pll, refuses vco source
// - switch waits three cycles of crystal, and of vco while pll runs, output held
// - switched clock halved, bus is quarter source
// - select bit picks crystal or vco clock
// - vco select blocked while pll off
// - pll off blocked while vco selected
// - power and select can change in one write
// - range zero forces crystal source
// - oscillator enable gates crystal and pll
// - base clock 50% duty, twice bus rate
// - interrupt output driven by lock detector
// - select one vco, zero crystal; reset/stop clear
// - reset sets pll power bit
// - auto mode: lock change sets flag, interrupt
// - program writes ignored while pll on
module pbcs_top #(
  parameter int SWITCH_CYC = `PBCS_SWITCH_CYC
) (
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RSTN,
  input  wire pbcs_pkg::pbcs_apb_req_s I_APB,
  output var  pbcs_pkg::pbcs_apb_rsp_s O_APB,
  input  wire logic                   I_XTAL_CLK,
  input  wire logic                   I_VCO_CLK,
  input  wire logic                   I_OSC_ENABLE,
  input  wire logic                   I_STOP,
  input  wire logic                   I_PLL_LOCK,
  input  wire logic                   I_PLL_ACQ_DONE,
  output logic                        O_BASE_CLK,
  output logic                        O_OSC_EN,
  output var  pbcs_pkg::pbcs_pll_cfg_s O_PLL_CFG,
  output logic                        O_VCO_ACTIVE,
  output logic                        O_SWITCHING,
  output logic                        O_PLL_IRQ
);
  import pbcs_pkg::*;

  // the counters below are two bits wide; refused at elaboration so a
  // bad value never reaches a netlist
  if (SWITCH_CYC < 1 || SWITCH_CYC > 3) begin : g_bad_cyc
    $error("SWITCH_CYC must lie in 1..3");
  end


  localparam logic [1:0] SW_LAST = 2'(SWITCH_CYC);

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic       ie_q,   ie_d;
  logic       flag_q, flag_d;
  logic       on_q,   on_d;
  logic       sel_q,  sel_d;
  logic       auto_q, auto_d;
  logic       acq_q,  acq_d;
  logic [3:0] mul_q,  mul_d;
  logic [3:0] vrs_q,  vrs_d;
  logic       lock_q;
  pbcs_apb_rsp_s rsp_q, rsp_d;

  logic       setup, done, wr, rd;
  logic       hit_ctrl, hit_bw, hit_prog;
  logic       lock_edge;
  logic [7:0] ctrl_rd, bw_rd, prog_rd;

  // a transfer completes at the edge where our registered pready is seen
  assign setup     = I_APB.psel && I_APB.penable && !rsp_q.pready;
  assign done      = I_APB.psel && I_APB.penable && rsp_q.pready;
  assign wr        = done && I_APB.pwrite;
  assign rd        = done && !I_APB.pwrite;
  assign hit_ctrl  = (I_APB.paddr == `PBCS_ADDR_CTRL);
  assign hit_bw    = (I_APB.paddr == `PBCS_ADDR_BW);
  assign hit_prog  = (I_APB.paddr == `PBCS_ADDR_PROG);
  assign lock_edge = auto_q && (I_PLL_LOCK != lock_q);

  // read views; enable and flag read zero in manual mode
  assign ctrl_rd = {ie_q && auto_q, flag_q && auto_q, on_q, sel_q,
                    `PBCS_CTRL_ONES};
  assign bw_rd   = {auto_q, I_PLL_LOCK && auto_q,
                    auto_q ? I_PLL_ACQ_DONE : acq_q, 5'h00};
  assign prog_rd = {mul_q, vrs_q};

  // next register values
  always_comb begin
    ie_d   = ie_q;
    on_d   = on_q;
    sel_d  = sel_q;
    auto_d = auto_q;
    acq_d  = acq_q;
    mul_d  = mul_q;
    vrs_d  = vrs_q;
    flag_d = flag_q;
    rsp_d  = '0;
    // answer one cycle after the access phase opens
    if (setup) begin
      rsp_d.pready  = 1'b1;
      rsp_d.pslverr = !(hit_ctrl || hit_bw || hit_prog);
      rsp_d.prdata  = hit_ctrl ? {24'h000000, ctrl_rd} :
                      hit_bw   ? {24'h000000, bw_rd}   :
                      hit_prog ? {24'h000000, prog_rd} : 32'h00000000;
    end
    // reading control clears the flag; a lock change seen now wins
    if (rd && hit_ctrl) begin
      flag_d = 1'b0;
    end
    if (lock_edge) begin
      flag_d = 1'b1;
    end
    if (wr && hit_ctrl) begin
      if (auto_q) begin
        ie_d = I_APB.pwdata[`PBCS_CTRL_IE];
      end
      // both interlocks look at the old values, so one write can turn
      // power off and select the vco together
      if (I_APB.pwdata[`PBCS_CTRL_ON] || !sel_q) begin
        on_d = I_APB.pwdata[`PBCS_CTRL_ON];
      end
      if (!I_APB.pwdata[`PBCS_CTRL_SEL]) begin
        sel_d = 1'b0;
      end else if (on_q && vrs_q != `PBCS_CODE_ZERO) begin
        sel_d = 1'b1;
      end
    end
    if (wr && hit_bw) begin
      auto_d = I_APB.pwdata[`PBCS_BW_AUTO];
      // in auto mode the manual value is kept aside, not overwritten
      if (!auto_q) begin
        acq_d = I_APB.pwdata[`PBCS_BW_ACQ];
      end
    end
    if (wr && hit_prog && !on_q) begin
      mul_d = I_APB.pwdata[7:4];
      vrs_d = I_APB.pwdata[3:0];
    end
    // range zero or stop mode drops the vco selection
    if (vrs_d == `PBCS_CODE_ZERO || I_STOP) begin
      sel_d = 1'b0;
    end
  end

  // register flops; power bit comes up set so the loop settles early
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ie_q   <= 1'b0;
      flag_q <= 1'b0;
      on_q   <= 1'b1;
      sel_q  <= 1'b0;
      auto_q <= 1'b0;
      acq_q  <= 1'b0;
      mul_q  <= `PBCS_MUL_RST;
      vrs_q  <= `PBCS_VRS_RST;
      lock_q <= 1'b0;
      rsp_q  <= '0;
    end else begin
      ie_q   <= ie_d;
      flag_q <= flag_d;
      on_q   <= on_d;
      sel_q  <= sel_d;
      auto_q <= auto_d;
      acq_q  <= acq_d;
      mul_q  <= mul_d;
      vrs_q  <= vrs_d;
      lock_q <= I_PLL_LOCK;
      rsp_q  <= rsp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pll settings, oscillator enable and interrupt
  pbcs_pll_cfg_s cfg_d, cfg_q;
  logic          pll_live;
  logic          osc_q, irq_q;

  assign pll_live = on_q && I_OSC_ENABLE && vrs_q != `PBCS_CODE_ZERO;

  // settings seen by the analog loop
  always_comb begin
    cfg_d.enable = pll_live;
    cfg_d.track  = auto_q ? I_PLL_ACQ_DONE : acq_q;
    cfg_d.mul    = (mul_q == `PBCS_CODE_ZERO) ? `PBCS_MUL_ONE
                                              : mul_q;
    cfg_d.vrs    = vrs_q;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_q <= '0;
      osc_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      osc_q <= I_OSC_ENABLE;
      irq_q <= flag_q && ie_q && auto_q;
    end
  end

  assign O_APB     = rsp_q;
  assign O_PLL_CFG = cfg_q;
  assign O_OSC_EN  = osc_q;
  assign O_PLL_IRQ = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // source switch and divide by two
  pbcs_sw_e   st_q, st_d;
  logic       src_q, src_d;
  logic       xprev_q, vprev_q;
  logic [1:0] xcnt_q, xcnt_d, vcnt_q, vcnt_d;
  logic       base_q, base_d;
  logic       want, xrise, vrise, vdone;

  // the vco only counts as a source while the loop really runs
  assign want  = sel_q && pll_live;
  assign xrise = I_XTAL_CLK && !xprev_q;
  assign vrise = I_VCO_CLK && !vprev_q;
  // a stopped vco never ticks, so its wait is skipped when it is off
  assign vdone = (vcnt_q == SW_LAST) || !pll_live;

  // hand-over: each source is counted on its own edges, so neither is
  // dropped mid-pulse and the output stays still until both agree
  always_comb begin
    st_d   = st_q;
    src_d  = src_q;
    xcnt_d = xcnt_q;
    vcnt_d = vcnt_q;
    base_d = base_q;
    unique case (st_q)
      PBCS_RUN: begin
        if (want != src_q) begin
          st_d   = PBCS_HOLD;
          xcnt_d = 2'h0;
          vcnt_d = 2'h0;
        end else if (src_q ? vrise : xrise) begin
          base_d = !base_q;
        end
      end
      PBCS_HOLD: begin
        if (xrise && xcnt_q != SW_LAST) begin
          xcnt_d = xcnt_q + 2'h1;
        end
        if (vrise && vcnt_q != SW_LAST) begin
          vcnt_d = vcnt_q + 2'h1;
        end
        if (want == src_q) begin
          st_d = PBCS_RUN;
        end else if (xcnt_q == SW_LAST && vdone) begin
          st_d  = PBCS_RUN;
          src_d = want;
        end
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q    <= PBCS_RUN;
      src_q   <= 1'b0;
      xprev_q <= 1'b0;
      vprev_q <= 1'b0;
      xcnt_q  <= 2'h0;
      vcnt_q  <= 2'h0;
      base_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      src_q   <= src_d;
      xprev_q <= I_XTAL_CLK;
      vprev_q <= I_VCO_CLK;
      xcnt_q  <= xcnt_d;
      vcnt_q  <= vcnt_d;
      base_q  <= base_d;
    end
  end

  assign O_BASE_CLK   = base_q;
  assign O_VCO_ACTIVE = src_q;
  assign O_SWITCHING  = (st_q == PBCS_HOLD);

endmodule

`default_nettype wire

/* File: sim/pbcs_chk.sv */
// assertions of the base clock selector, bound to every pbcs_top
// assumes one system clock and the async active-low reset
`timescale 1ns/10ps
`default_nettype none
module pbcs_chk #(
  parameter int SWITCH_CYC = 3
) (
  input wire logic                    I_SYS_CLK,
  input wire logic                    I_RSTN,
  input wire pbcs_pkg::pbcs_apb_req_s I_APB,
  input wire pbcs_pkg::pbcs_apb_rsp_s O_APB,
  input wire logic                    I_PLL_LOCK,
  input wire logic                    O_BASE_CLK,
  input wire logic                    O_OSC_EN,
  input wire pbcs_pkg::pbcs_pll_cfg_s O_PLL_CFG,
  input wire logic                    O_VCO_ACTIVE,
  input wire logic                    O_SWITCHING,
  input wire logic                    O_PLL_IRQ
);
  import pbcs_pkg::*;
  logic [2:0] since_q;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  ////////////////////////////////////////////////////////////////////////
  // cycles since the lock level moved; saturates so old changes fade
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) since_q <= 3'h7;
    else if ($changed(I_PLL_LOCK)) since_q <= 3'h0;
    else if (since_q != 3'h7) since_q <= since_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  // the settings register holds zeros in reset, so skip the first edge
  mul_nonzero_a: assert property ($past(I_RSTN) |->
    O_PLL_CFG.mul != 4'h0) else $error("multiplier zero");
  range_off_a: assert property (O_PLL_CFG.vrs == 4'h0 |->
    !O_PLL_CFG.enable) else $error("pll on with range zero");
  osc_gate_a: assert property (O_PLL_CFG.enable |-> O_OSC_EN)
    else $error("pll on without oscillator");
  hold_still_a: assert property (O_SWITCHING && $past(O_SWITCHING)
    |-> $stable(O_BASE_CLK)) else $error("base moved in switch");
  // a hand-over may be abandoned early; only a completed one is timed
  switch_min_a: assert property ($fell(O_SWITCHING) &&
    $changed(O_VCO_ACTIVE) |-> $past(O_SWITCHING, 3))
    else $error("switch too short");
  switch_end_a: assert property ($rose(O_SWITCHING)
    |-> ##[1:200] !O_SWITCHING) else $error("switch hangs");
  vco_entry_a: assert property ($rose(O_VCO_ACTIVE)
    |-> $past(O_SWITCHING) && O_PLL_CFG.enable) else $error("bad vco entry");
  toggle_run_a: assert property ($changed(O_BASE_CLK)
    |-> !$past(O_SWITCHING)) else $error("base toggled in switch");
  irq_cause_a: assert property ($rose(O_PLL_IRQ)
    |-> since_q inside {[1:4]}) else $error("irq without lock change");
  ready_one_a: assert property (I_APB.psel && I_APB.penable &&
    !O_APB.pready |=> O_APB.pready ##1 !O_APB.pready)
    else $error("apb ready timing");
  cover property ($rose(O_VCO_ACTIVE));
  cover property ($fell(O_VCO_ACTIVE));
  cover property ($rose(O_PLL_IRQ));
endmodule
bind pbcs_top pbcs_chk #(.SWITCH_CYC(SWITCH_CYC)) u_chk (.*);
`default_nettype wire

/* File: sim/pbcs_pll_model.sv */
// behavioural crystal and pll: free crystal, gated vco, settling lock
// assumes the cfg struct of the selector and its 20 MHz clock
`timescale 1ns/10ps
`default_nettype none
module pbcs_pll_model #(
  parameter int SETTLE = 40
) (
  input  wire logic                    i_clk,
  input  wire pbcs_pkg::pbcs_pll_cfg_s i_cfg,
  output logic                         o_xtal,
  output logic                         o_vco,
  output logic                         o_lock
);
  import pbcs_pkg::*;
  logic [7:0] cnt_q = 8'h00;
  // crystal runs free, period ten system cycles
  initial begin
    o_xtal = 1'b0;
    forever begin
      repeat (5) @(posedge i_clk);
      o_xtal <= ~o_xtal;
    end
  end
  // vco stands still while disabled, lock only after settling
  initial o_lock = 1'b0;
  always @(posedge i_clk) begin
    cnt_q <= i_cfg.enable ? cnt_q + 8'h01 : 8'h00;
    o_lock <= i_cfg.enable & (o_lock | (cnt_q == SETTLE[7:0]));
  end
  assign o_vco = cnt_q[1];
endmodule
`default_nettype wire

/* File: sim/pbcs_top_bench.sv */
// self-checking bench of the base clock selector over apb
// assumes the pll model as far side and oscillator enable held high
`timescale 1ns/10ps
`default_nettype none
module pbcs_top_bench;
  import pbcs_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } pbcs_row_s;
  logic          clk, rstn, xtal, vco, lock, base, osc, act, sw, irq, err;
  logic          stop;
  logic [31:0]   rd;
  int            n_errors, tests_run, n;
  pbcs_apb_req_s req;
  pbcs_apb_rsp_s rsp;
  pbcs_pll_cfg_s cfg;
  // write then read back; last row is unmapped
  pbcs_row_s rows [10] = '{'{8'h78, 8'h00, 8'h66}, '{8'h70, 8'h00, 8'h0f},
    '{8'h78, 8'h00, 8'h00}, '{8'h70, 8'h30, 8'h2f}, '{8'h70, 8'h30, 8'h2f},
    '{8'h70, 8'h00, 8'h0f}, '{8'h78, 8'h82, 8'h82}, '{8'h74, 8'h80, 8'h80},
    '{8'h70, 8'ha0, 8'haf}, '{8'h7c, 8'hff, 8'h00}};
  pbcs_top u_dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_APB(req),
    .O_APB(rsp), .I_XTAL_CLK(xtal), .I_VCO_CLK(vco), .I_OSC_ENABLE(1'b1),
    .I_STOP(stop), .I_PLL_LOCK(lock), .I_PLL_ACQ_DONE(lock),
    .O_BASE_CLK(base), .O_OSC_EN(osc), .O_PLL_CFG(cfg),
    .O_VCO_ACTIVE(act), .O_SWITCHING(sw), .O_PLL_IRQ(irq));
  pbcs_pll_model u_pll (.i_clk(clk), .i_cfg(cfg), .o_xtal(xtal),
    .o_vco(vco), .o_lock(lock));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    chk(rsp.pready, 1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  // cycles that the base clock spends high
  task automatic hi_len(output int c);
    c = 0;
    do @(posedge clk); while (base !== 1'b0);
    do @(posedge clk); while (base !== 1'b1);
    do begin
      @(posedge clk);
      c++;
    end while (base === 1'b1 && c < 99);
  endtask
  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 200 && s !== 1'b1; k++) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #250000;
    n_errors++;
    print_verdict;
  end
  initial begin
    rstn = 1'b0;
    req = '0;
    stop = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    hi_len(n);
    chk(n, 10);
    chk(osc, 1);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      chk(rd, rows[i].e);
      chk(err, rows[i].a == 8'h7c);
    end
    wait_hi(irq);
    chk(irq, 1);
    chk(cfg, {1'b1, 1'b1, 4'h8, 4'h2});
    apb(1'b0, 8'h70, 8'h00);
    chk(rd, 32'hef);
    @(posedge clk);
    chk(irq, 0);
    apb(1'b1, 8'h70, 8'hb0);
    wait_hi(act);
    chk(act, 1);
    chk(sw, 0);
    hi_len(n);
    chk(n, 4);
    apb(1'b1, 8'h70, 8'h80);
    apb(1'b0, 8'h70, 8'h00);
    chk(rd, 32'haf);
    // stop mode drops a fresh vco selection, power stays on
    apb(1'b1, 8'h70, 8'hb0);
    stop <= 1'b1;
    apb(1'b0, 8'h70, 8'h00);
    stop <= 1'b0;
    chk(rd, 32'haf);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h70, 8'h00);
    chk(rd, 32'h2f);
    apb(1'b0, 8'h78, 8'h00);
    chk(rd, 32'h66);
    print_verdict;
  end
endmodule
`default_nettype wire
